// File: atc_pkg.sv
// Package of constants for the arm and trigger control block.
// Assumes byte-wide registers on a one-byte offset space.
package atc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_ARM_IMM = 8'h41;
  localparam logic [7:0] OFS_INITIATE = 8'h45;
  localparam logic [7:0] OFS_SW_ARM = 8'h47;
  localparam logic [7:0] OFS_ARM_SRC = 8'h49;
  localparam logic [7:0] OFS_ARM_CTRL = 8'h4b;
  // ----------------------------------------
  // Values after reset and control write mask
  // ----------------------------------------
  localparam logic [7:0] RST_ARM_SRC = 8'h7f;
  localparam logic [7:0] RST_ARM_CTRL = 8'h01;
  localparam logic [7:0] CTRL_WR_MASK = 8'h7f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SRC2_NEG_BIT = 7;
  localparam int SRC2_LSB = 4;
  localparam int SRC1_NEG_BIT = 3;
  localparam int SRC1_LSB = 0;
  localparam int CTRL_IRQ_EN_BIT = 6;
  localparam int CTRL_DUAL_BIT = 5;
  localparam int CTRL_RECLK_BIT = 4;
  localparam int CTRL_PREPOST_BIT = 3;
  localparam int CTRL_HOLD_BIT = 2;
  localparam int CTRL_UNLIM_BIT = 1;
  localparam int CTRL_DLYREF_BIT = 0;
  // ----------------------------------------
  // Arm source codes
  // ----------------------------------------
  localparam logic [2:0] SRC_FRONT_ONE = 3'h0;
  localparam logic [2:0] SRC_TTL = 3'h1;
  localparam logic [2:0] SRC_GET = 3'h2;
  localparam logic [2:0] SRC_CH1_LEVEL = 3'h3;
  localparam logic [2:0] SRC_CH2_LEVEL = 3'h4;
  localparam logic [2:0] SRC_ECL_ZERO = 3'h5;
  localparam logic [2:0] SRC_ECL_ONE = 3'h6;
  localparam logic [2:0] SRC_OFF_OR_IMM = 3'h7;
  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  localparam int PIN_COUNT = 6;
endpackage

// File: atc_edge_sync.sv
// Two-stage synchroniser with rise and fall pulse outputs.
// Assumes a pin from an unrelated domain; pulses are one cycle wide.
`timescale 1ns/100ps
`default_nettype none
module atc_edge_sync (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pinIn,
  output logic risePulse,
  output logic fallPulse
);
  logic meta_ff, sync_ff, last_ff;
  logic nxt_meta, nxt_sync, nxt_last;

  always_comb begin
    nxt_meta = pinIn;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // Edges seen only after the second stage
  assign risePulse = sync_ff & ~last_ff;
  assign fallPulse = ~sync_ff & last_ff;
endmodule
`default_nettype wire

// File: atc_src_mux.sv
// Arm source selector: picks one event by code and slope.
// Assumes edge pulses indexed by source code; software trigger ignores slope.
`timescale 1ns/100ps
`default_nettype none
module atc_src_mux (
  input wire logic [2:0] srcSel,
  input wire logic negSlope,
  input wire logic [7:0] riseVec,
  input wire logic [7:0] fallVec,
  input wire logic swTrig,
  output logic armEvt
);
  logic [7:0] edgeVec;

  always_comb begin
    edgeVec = negSlope ? fallVec : riseVec;
    if (srcSel == atc_pkg::SRC_OFF_OR_IMM) begin
      armEvt = 1'b0;
    end else if (srcSel == atc_pkg::SRC_GET) begin
      armEvt = swTrig;
    end else begin
      armEvt = edgeVec[srcSel];
    end
  end
endmodule
`default_nettype wire

// File: atc_arm_trigger_control.sv
// Arm and initiation control registers of the timebase processor.
// Assumes a byte register port on ref_clk and arm pins from other domains.
`timescale 1ns/100ps
`default_nettype none
module atc_arm_trigger_control (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic frontInputOne,
  input wire logic ttl_backplane_line,
  input wire logic chanOneLevel,
  input wire logic chanTwoLevel,
  input wire logic ecl_backplane_line_zero,
  input wire logic ecl_backplane_line_one,
  input wire logic sampleSrcIsGet,
  input wire logic digitizerArmed,
  input wire logic armCountReached,
  output logic initiatePulse,
  output logic sampleTrigPulse,
  output logic armPulse,
  output logic goIdlePulse,
  output logic localIrqZero,
  output logic dualRateMode,
  output logic reclkByDiv10,
  output logic prePostArm,
  output logic armHold,
  output logic armUnlimited,
  output logic armDelayRefClk
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] armSrc_ff, nxt_armSrc;
  logic [7:0] armCtrl_ff, nxt_armCtrl;
  logic [7:0] rdData_ff, nxt_rdData;
  logic initiate_ff, nxt_initiate;
  logic sample_ff, nxt_sample;
  logic arm_ff, nxt_arm;
  logic goIdle_ff, nxt_goIdle;
  logic irq_ff, nxt_irq;
  logic wrInit, rdInit, wrSwArm, wrArmImm, wrSrc, wrCtrl;
  logic evtOne, evtTwo, anyEvt, immArm, armOk;
  logic [atc_pkg::PIN_COUNT-1:0] pinVec, riseRaw, fallRaw;
  logic [7:0] riseVec, fallVec;
  logic [2:0] srcOneSel, srcTwoSel;

  assign wrInit = regWr && regAddr == atc_pkg::OFS_INITIATE;
  assign rdInit = regRd && regAddr == atc_pkg::OFS_INITIATE;
  assign wrSwArm = regWr && regAddr == atc_pkg::OFS_SW_ARM;
  assign wrArmImm = regWr && regAddr == atc_pkg::OFS_ARM_IMM;
  assign wrSrc = regWr && regAddr == atc_pkg::OFS_ARM_SRC;
  assign wrCtrl = regWr && regAddr == atc_pkg::OFS_ARM_CTRL;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign pinVec = {ecl_backplane_line_one, ecl_backplane_line_zero, chanTwoLevel,
                   chanOneLevel, ttl_backplane_line, frontInputOne};

  genvar gi;
  generate
    for (gi = 0; gi < atc_pkg::PIN_COUNT; gi++) begin : g_pin
      atc_edge_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pinIn(pinVec[gi]),
        .risePulse(riseRaw[gi]),
        .fallPulse(fallRaw[gi])
      );
    end
  endgenerate

  // Index by source code; code 2 is the software trigger, code 7 has no pin
  assign riseVec = {1'b0, riseRaw[5:2], 1'b0, riseRaw[1:0]};
  assign fallVec = {1'b0, fallRaw[5:2], 1'b0, fallRaw[1:0]};

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // source two code
  assign srcTwoSel = armSrc_ff[atc_pkg::SRC2_LSB +: 3];
  assign srcOneSel = armSrc_ff[atc_pkg::SRC1_LSB +: 3];

  atc_src_mux u_mux_one (
    .srcSel(srcOneSel),
    .negSlope(armSrc_ff[atc_pkg::SRC1_NEG_BIT]),
    .riseVec(riseVec),
    .fallVec(fallVec),
    .swTrig(wrSwArm),
    .armEvt(evtOne)
  );

  atc_src_mux u_mux_two (
    .srcSel(srcTwoSel),
    .negSlope(armSrc_ff[atc_pkg::SRC2_NEG_BIT]),
    .riseVec(riseVec),
    .fallVec(fallVec),
    .swTrig(wrSwArm),
    .armEvt(evtTwo)
  );

  // immediate arm follows initiation
  // Software must keep source two off here, else its edges also arm
  assign immArm = initiate_ff && srcOneSel == atc_pkg::SRC_OFF_OR_IMM;

  assign anyEvt = evtOne | evtTwo | immArm;

  // hold passes only the immediate write
  assign armOk = wrArmImm |
                 (anyEvt & ~armCtrl_ff[atc_pkg::CTRL_HOLD_BIT] & ~digitizerArmed &
                  (armCtrl_ff[atc_pkg::CTRL_UNLIM_BIT] | ~armCountReached));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_armSrc = armSrc_ff;
    nxt_armCtrl = armCtrl_ff;
    if (wrSrc) begin
      nxt_armSrc = regWrData;
    end
    if (wrCtrl) begin
      nxt_armCtrl = regWrData & atc_pkg::CTRL_WR_MASK;
    end
    if (wrInit) begin
      nxt_armCtrl[atc_pkg::CTRL_IRQ_EN_BIT] = 1'b0;
    end
    nxt_initiate = wrInit;
    nxt_sample = rdInit & sampleSrcIsGet;
    nxt_arm = armOk;
    // idle when limit turns back on
    nxt_goIdle = wrCtrl & armCtrl_ff[atc_pkg::CTRL_UNLIM_BIT] &
                 ~regWrData[atc_pkg::CTRL_UNLIM_BIT] & armCountReached;
    // sticky while enabled; a cleared enable wins over a new event
    nxt_irq = armCtrl_ff[atc_pkg::CTRL_IRQ_EN_BIT] &
              (irq_ff | (anyEvt & (armCtrl_ff[atc_pkg::CTRL_HOLD_BIT] | digitizerArmed)));
    nxt_rdData = 8'h00;
    if (regRd && regAddr == atc_pkg::OFS_ARM_SRC) begin
      nxt_rdData = armSrc_ff;
    end else if (regRd && regAddr == atc_pkg::OFS_ARM_CTRL) begin
      nxt_rdData = armCtrl_ff;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      armSrc_ff <= atc_pkg::RST_ARM_SRC;
      armCtrl_ff <= atc_pkg::RST_ARM_CTRL;
      rdData_ff <= 8'h00;
      initiate_ff <= 1'b0;
      sample_ff <= 1'b0;
      arm_ff <= 1'b0;
      goIdle_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      armSrc_ff <= nxt_armSrc;
      armCtrl_ff <= nxt_armCtrl;
      rdData_ff <= nxt_rdData;
      initiate_ff <= nxt_initiate;
      sample_ff <= nxt_sample;
      arm_ff <= nxt_arm;
      goIdle_ff <= nxt_goIdle;
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regRdData = rdData_ff;
  assign initiatePulse = initiate_ff;
  assign sampleTrigPulse = sample_ff;
  assign armPulse = arm_ff;
  assign goIdlePulse = goIdle_ff;
  assign localIrqZero = irq_ff;
  assign dualRateMode = armCtrl_ff[atc_pkg::CTRL_DUAL_BIT];
  assign reclkByDiv10 = armCtrl_ff[atc_pkg::CTRL_RECLK_BIT];
  assign prePostArm = armCtrl_ff[atc_pkg::CTRL_PREPOST_BIT];
  assign armHold = armCtrl_ff[atc_pkg::CTRL_HOLD_BIT];
  assign armUnlimited = armCtrl_ff[atc_pkg::CTRL_UNLIM_BIT];
  assign armDelayRefClk = armCtrl_ff[atc_pkg::CTRL_DLYREF_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_init_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    initiatePulse |-> $past(regWr) && $past(regAddr) == 8'h45)
    else $error("initiate pulse without write");
  a_sample_get: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(sampleTrigPulse) || sampleTrigPulse |-> $past(rdInit) && $past(sampleSrcIsGet))
    else $error("sample trigger without GET read");
  a_sw_arm_path: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrSwArm && srcOneSel == 3'h2 && !armHold && !digitizerArmed && !armCountReached
    |=> armPulse)
    else $error("software arm lost");
  a_reset_src: assert property (@(posedge ref_clk)
    !rst_b |=> regRdData == 8'h00 && armSrc_ff == 8'h7f)
    else $error("arm source reset value wrong");
  a_reset_ctrl: assert property (@(posedge ref_clk)
    !rst_b |=> armCtrl_ff == 8'h01 && !localIrqZero)
    else $error("arm control reset value wrong");
  a_hold_block: assert property (@(posedge ref_clk) disable iff (!rst_b)
    armHold && !wrArmImm |=> !armPulse)
    else $error("arm accepted during hold");
  a_imm_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrArmImm |=> armPulse)
    else $error("immediate arm write lost");
  a_irq_enable: assert property (@(posedge ref_clk) disable iff (!rst_b)
    armCtrl_ff[6] && anyEvt && (armHold || digitizerArmed) |=> localIrqZero)
    else $error("interrupt not raised");
  a_init_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrInit |=> !armCtrl_ff[6] ##1 !localIrqZero)
    else $error("enable not cleared by initiation");
  a_limit_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrCtrl && armUnlimited && !regWrData[1] && armCountReached |=> goIdlePulse && !armUnlimited)
    else $error("idle not requested");
  a_limit_stop: assert property (@(posedge ref_clk) disable iff (!rst_b)
    anyEvt && !wrArmImm && armCountReached && !armUnlimited |=> !armPulse)
    else $error("arm past count without unlimited");

  // ----------------------------------------
  // Checks on selection, control bits and pin edge pulses
  // ----------------------------------------
  a_src_or_two: assert property (@(posedge ref_clk) disable iff (!rst_b)
    evtTwo && !armHold && !digitizerArmed && !armCountReached |=> armPulse)
    else $error("source two arm lost");
  a_src_two_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    srcTwoSel == atc_pkg::SRC_OFF_OR_IMM |-> !evtTwo)
    else $error("disabled source two produced an event");
  a_imm_arm: assert property (@(posedge ref_clk) disable iff (!rst_b)
    initiatePulse && srcOneSel == atc_pkg::SRC_OFF_OR_IMM && !armHold && !digitizerArmed && !armCountReached
    |=> armPulse)
    else $error("immediate arm after initiation lost");
  a_slope_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
    riseVec[srcOneSel] && !armSrc_ff[atc_pkg::SRC1_NEG_BIT] |-> evtOne)
    else $error("rising edge on source one missed");
  a_slope_fall: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fallVec[srcTwoSel] && armSrc_ff[atc_pkg::SRC2_NEG_BIT] |-> evtTwo)
    else $error("falling edge on source two missed");
  a_dual_rate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrCtrl |=> dualRateMode == $past(regWrData[atc_pkg::CTRL_DUAL_BIT]))
    else $error("dual rate bit not taken");
  a_reclk_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrCtrl |=> reclkByDiv10 == $past(regWrData[atc_pkg::CTRL_RECLK_BIT]))
    else $error("reclock bit not taken");
  a_prepost_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrCtrl |=> prePostArm == $past(regWrData[atc_pkg::CTRL_PREPOST_BIT]))
    else $error("pre and post bit not taken");
  a_delay_clk: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrCtrl |=> armDelayRefClk == $past(regWrData[atc_pkg::CTRL_DLYREF_BIT]))
    else $error("arm delay clock bit not taken");
  a_unlim_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
    anyEvt && armUnlimited && !armHold && !digitizerArmed |=> armPulse)
    else $error("unlimited arm refused");
  a_idle_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(wrCtrl && armUnlimited && !regWrData[atc_pkg::CTRL_UNLIM_BIT] && armCountReached) |=> !goIdlePulse)
    else $error("idle requested without cause");
  a_pin_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (riseRaw & $past(riseRaw)) == 6'h00 && (fallRaw & $past(fallRaw)) == 6'h00)
    else $error("pin edge pulse longer than one cycle");
endmodule
`default_nettype wire

// File: atc_pin_model.sv
// Behavioural model of the six external arm pins.
// Assumes toggle requests on ref_clk; pins then move off the edge like an unrelated source.
`timescale 1ns/100ps
`default_nettype none
module atc_pin_model (
  input wire logic ref_clk,
  input wire logic [5:0] flipReq,
  output logic [5:0] pins
);
  initial pins = 6'h00;
  // Odd delay keeps pin changes away from the sampling edge
  always @(posedge ref_clk) begin
    pins <= #3.3 pins ^ flipReq;
  end
endmodule
`default_nettype wire

// File: atc_arm_trigger_control_tb.sv
// Testbench for the arm and trigger control register block.
// Assumes the pin model drives the arm pins; same-clock levels come from here.
`timescale 1ns/100ps
`default_nettype none
module atc_arm_trigger_control_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rdVal;
  logic regWr = 1'b0, regRd = 1'b0;
  logic sampleSrcIsGet = 1'b0, digitizerArmed = 1'b0, armCountReached = 1'b0;
  logic [5:0] flipReq = 6'h00;
  logic [5:0] pins;
  logic [7:0] regRdData;
  logic initiatePulse, sampleTrigPulse, armPulse, goIdlePulse, localIrqZero;
  logic dualRateMode, reclkByDiv10, prePostArm, armHold, armUnlimited, armDelayRefClk;
  logic [7:0] ctrlBits;
  assign ctrlBits = {2'h0, dualRateMode, reclkByDiv10, prePostArm, armHold, armUnlimited, armDelayRefClk};
  logic [2:0] codes [6] = '{atc_pkg::SRC_FRONT_ONE, atc_pkg::SRC_TTL, atc_pkg::SRC_CH1_LEVEL,
    atc_pkg::SRC_CH2_LEVEL, atc_pkg::SRC_ECL_ZERO, atc_pkg::SRC_ECL_ONE};
  int nMismatch = 0, checks = 0, cycles = 0;
  int nInit = 0, nSamp = 0, nArm = 0, nIdle = 0, bInit, bSamp, bArm, bIdle;
  always #4 ref_clk = ~ref_clk;
  atc_pin_model pin_u (.ref_clk, .flipReq, .pins);
  atc_arm_trigger_control dut_u (.ref_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .frontInputOne(pins[0]), .ttl_backplane_line(pins[1]), .chanOneLevel(pins[2]),
    .chanTwoLevel(pins[3]), .ecl_backplane_line_zero(pins[4]), .ecl_backplane_line_one(pins[5]),
    .sampleSrcIsGet, .digitizerArmed, .armCountReached, .initiatePulse, .sampleTrigPulse,
    .armPulse, .goIdlePulse, .localIrqZero, .dualRateMode, .reclkByDiv10, .prePostArm,
    .armHold, .armUnlimited, .armDelayRefClk);
  // ----------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    nInit <= nInit + int'(initiatePulse === 1'b1);
    nSamp <= nSamp + int'(sampleTrigPulse === 1'b1);
    nArm <= nArm + int'(armPulse === 1'b1);
    nIdle <= nIdle + int'(goIdlePulse === 1'b1);
    if (cycles == 3000) begin
      nMismatch++;
      wrapUp();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic mark();
    bInit = nInit;
    bSamp = nSamp;
    bArm = nArm;
    bIdle = nIdle;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    settle(3);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    rdVal = regRdData;
    settle(2);
  endtask
  task automatic lvl(input logic g, input logic a, input logic c);
    @(posedge ref_clk);
    sampleSrcIsGet <= g;
    digitizerArmed <= a;
    armCountReached <= c;
  endtask
  task automatic flip(input int i);
    @(posedge ref_clk);
    flipReq <= 6'h01 << i;
    @(posedge ref_clk);
    flipReq <= 6'h00;
    settle(8);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkN(input int got, input int exp);
    checks++;
    if (got != exp) begin
      nMismatch++;
      $display("[FAIL] %0t pulse count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wrapUp();
    $display("mismatches %0d checks %0d", nMismatch, checks);
    if (nMismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(atc_pkg::OFS_ARM_SRC);
    chk8(rdVal, 8'h7f);
    rd(atc_pkg::OFS_ARM_CTRL);
    chk8(rdVal, 8'h01);
    rd(8'h4d);
    chk8(rdVal, 8'h00);
    wr(atc_pkg::OFS_ARM_CTRL, 8'hbf);
    rd(atc_pkg::OFS_ARM_CTRL);
    chk8(rdVal, 8'h3f);
    chk8(ctrlBits, 8'h3f);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h40);
    chk8(ctrlBits, 8'h00);
    $display("test registers done");
    mark();
    wr(atc_pkg::OFS_INITIATE, 8'ha5);
    chkN(nInit - bInit, 1);
    chkN(nArm - bArm, 1);
    rd(atc_pkg::OFS_ARM_CTRL);
    chk8(rdVal, 8'h00);
    rd(atc_pkg::OFS_INITIATE);
    chkN(nSamp - bSamp, 0);
    lvl(1'b1, 1'b0, 1'b0);
    rd(atc_pkg::OFS_INITIATE);
    chkN(nSamp - bSamp, 1);
    $display("test initiate done");
    // Source two off while source one is the trigger command
    wr(atc_pkg::OFS_ARM_SRC, 8'h72);
    mark();
    wr(atc_pkg::OFS_SW_ARM, 8'h00);
    chkN(nArm - bArm, 1);
    wr(atc_pkg::OFS_ARM_SRC, 8'ha0);
    wr(atc_pkg::OFS_SW_ARM, 8'h5a);
    chkN(nArm - bArm, 2);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h04);
    wr(atc_pkg::OFS_SW_ARM, 8'h00);
    chkN(nArm - bArm, 2);
    wr(atc_pkg::OFS_ARM_IMM, 8'h00);
    chkN(nArm - bArm, 3);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h00);
    $display("test software arm done");
    for (int k = 0; k < 6; k++) begin
      wr(atc_pkg::OFS_ARM_SRC, {5'h0e, codes[k]});
      mark();
      flip(k);
      chkN(nArm - bArm, 1);
      flip(k);
      chkN(nArm - bArm, 1);
    end
    wr(atc_pkg::OFS_ARM_SRC, 8'h90);
    mark();
    flip(1);
    chkN(nArm - bArm, 0);
    flip(1);
    chkN(nArm - bArm, 1);
    $display("test pins done");
    wr(atc_pkg::OFS_ARM_SRC, 8'h72);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h40);
    lvl(1'b0, 1'b1, 1'b0);
    wr(atc_pkg::OFS_SW_ARM, 8'h00);
    chk8({7'h0, localIrqZero}, 8'h01);
    wr(atc_pkg::OFS_INITIATE, 8'h00);
    chk8({7'h0, localIrqZero}, 8'h00);
    // Interrupt from an arm refused by hold
    lvl(1'b0, 1'b0, 1'b0);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h44);
    mark();
    wr(atc_pkg::OFS_SW_ARM, 8'h00);
    chk8({7'h0, localIrqZero}, 8'h01);
    chkN(nArm - bArm, 0);
    wr(atc_pkg::OFS_INITIATE, 8'h00);
    chk8({7'h0, localIrqZero}, 8'h00);
    lvl(1'b0, 1'b0, 1'b1);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h02);
    mark();
    wr(atc_pkg::OFS_SW_ARM, 8'h00);
    chkN(nArm - bArm, 1);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h00);
    chkN(nIdle - bIdle, 1);
    wr(atc_pkg::OFS_SW_ARM, 8'h00);
    chkN(nArm - bArm, 1);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h02);
    lvl(1'b0, 1'b0, 1'b0);
    wr(atc_pkg::OFS_ARM_CTRL, 8'h00);
    chkN(nIdle - bIdle, 1);
    $display("test interrupt and count done");
    // Reset in mid-run must bring back the reset values
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(atc_pkg::OFS_ARM_SRC);
    chk8(rdVal, 8'h7f);
    rd(atc_pkg::OFS_ARM_CTRL);
    chk8(rdVal, 8'h01);
    chk8(ctrlBits, 8'h01);
    $display("test second reset done");
    wrapUp();
  end
endmodule
`default_nettype wire
